// >>> design/line_cycle_energy_accumulator.sv
// Summary of operation
// RQ1 - Mode bits pick signed or absolute pulse output
// RQ2 - Line mode moves accumulations after counted crossings
// RQ3 - Line mode enable bit; clear means continuous
// RQ4 - Host keeps clear-on-read off in line mode
// RQ5 - Select bits choose counted phases, any mix
// RQ6 - Host selects one phase during calibration
// RQ7 - Sixteen-bit unsigned half cycle count
// RQ8 - Counter always runs; count write restarts it (code restarts it on a count write only in line mode)
// RQ9 - Period end sets done flag, masked interrupt
// RQ10 - Writing one clears done flag and interrupt
// RQ11 - Line mode shares ordinary energy path
// RQ12 - Reactive power: voltage times shifted current
// RQ13 - Store reactive power per phase, one sixteenth
// RQ14 - Host initialises frequency and nominal voltage
// RQ15 - Fundamental reactive settling time bounds
// RQ16 - Sample tick accumulates, thresholds, counts pulses
// RQ17 - Phase B power form selection field
// RQ18 - Counter restarts itself after each transfer
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "energy_acc_defs.svh"

module line_cycle_energy_accumulator
#(
    // Sample period in clock cycles; shorten for simulation
    parameter int unsigned SAMPLE_CYCLES =
        (`SAMPLE_PERIOD_US * `PS_PER_US) / `CLOCK_PERIOD_PS
)
(
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire energy_acc_pkg::avalonReq_s    avsReq,
    output logic [31:0]                        avs_readdata,
    output logic                               avs_waitrequest,
    input  wire energy_acc_pkg::phaseSample_s [2:0] samples,
    input  wire logic [2:0][47:0]              fundPower,
    input  wire logic [2:0]                    zeroCross,
    output logic                               pulse_frequency_output,
    output logic                               interrupt_out_n
);
    import energy_acc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [15:0] TICK_LAST = 16'(SAMPLE_CYCLES - 1);
    localparam accState_s ST_RESET = '{
        busState:   BUS_IDLE,
        waitreq:    1'b1,
        irqN:       1'b1,
        threshold:  `FULL_SCALE_POWER,
        halfCycles: `HALF_CYCLES_RESET,
        default:    '0
    };

    accState_s                st_r;          // Registered state
    accState_s                st_nxt;        // Next state
    logic                     zxDone;        // Period end from counter
    logic                     lineDone;      // Transfer strobe
    logic                     zxRestart;     // Counter restart request
    logic signed [25:0]       voltFormed [3];// Voltages after phase B form
    logic signed [49:0]       activePow [3]; // Instantaneous active power
    logic signed [49:0]       reactProd [3]; // Instantaneous reactive power
    logic signed [49:0]       chanPow [6];   // Total then fundamental
    logic signed [51:0]       firstSum;      // First-stage work value
    logic signed [51:0]       thrExt;        // Threshold, widened
    logic signed [31:0]       delta;         // Pulse of one channel
    logic signed [2:0]        netTotal;      // Net total pulses
    logic                     anyTotal;      // Any total pulse
    logic [5:0]               regIdx;        // Word index of request
    logic [31:0]              regWord;       // Addressed register value
    logic [31:0]              merged;        // Write data over old value
    logic [31:0]              clearBits;     // Status bits to clear
    logic                     readClear;     // Clear-on-read access
    logic signed [49:0]       reactShift;    // Scaled reactive power

    // Byte lanes of new data over old
    function automatic logic [31:0] beMerge(input logic [31:0] oldW,
                                           input logic [31:0] newW,
                                           input logic [3:0]  be);
        logic [31:0] res;
        res = oldW;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = newW[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------------
    // Phase B forming
    // ------------------------------------------------------------------
    // Widened by two bits so that minus A minus C cannot wrap
    always_comb
    begin
        voltFormed[0] = 26'(samples[0].volt);
        voltFormed[2] = 26'(samples[2].volt);
        case (st_r.phaseBForm)                                // see RQ17
            `PHB_NEG_A_C: voltFormed[1] = -voltFormed[0] - voltFormed[2];
            `PHB_NEG_A:   voltFormed[1] = -voltFormed[0];
            default:      voltFormed[1] = 26'(samples[1].volt);
        endcase
    end

    // ------------------------------------------------------------------
    // Per-phase products
    // ------------------------------------------------------------------
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        logic phaseOff;  // Phase B forced to zero
        assign phaseOff = (p == 1) && (st_r.phaseBForm == `PHB_ZERO);
        // Signed zero: an unsigned '0 here would zero-extend the operands
        assign activePow[p] = phaseOff ? 50'sh0
                            : voltFormed[p] * 50'(samples[p].curr);
        assign reactProd[p] = voltFormed[p] * 50'(samples[p].currQuad); // see RQ12
        assign chanPow[p]     = activePow[p];
        assign chanPow[p + 3] = phaseOff ? 50'sh0 : 50'(signed'(fundPower[p]));
    end

    // ------------------------------------------------------------------
    // Half line cycle counter
    // ------------------------------------------------------------------
    assign regIdx    = avsReq.address[7:2];
    assign zxRestart = (st_r.busState == BUS_ACK) && avsReq.write
                     && regIdx == `IDX_HALF_CYCLES
                     && st_r.lineEnable;                       // see RQ8
    assign lineDone  = zxDone && st_r.lineEnable;              // see RQ3

    zero_cross_counter u_counter
    (
        .clock       (clock),
        .rst_n       (rst_n),
        .zeroCross   (zeroCross),
        .phaseSelect (st_r.zxSelect),
        .target      (st_r.halfCycles),
        .restart     (zxRestart),
        .done        (zxDone)
    );

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    // Energy words read live in continuous mode, which is the
    // transfer-on-access; in line mode they show the last period.
    always_comb
    begin
        regWord = '0;
        case (regIdx)
            `IDX_ACC_MODE:
            begin
                regWord[`PULSE_MODE_MSB:`PULSE_MODE_LSB] = st_r.pulseMode;
                regWord[`PHASE_B_MSB:`PHASE_B_LSB]       = st_r.phaseBForm;
            end
            `IDX_LINE_MODE:
            begin
                regWord[`LINE_EN_BIT]              = st_r.lineEnable;
                regWord[`CLEAR_READ_BIT]           = st_r.clearOnRead;
                regWord[`ZX_SEL_MSB:`ZX_SEL_LSB]   = st_r.zxSelect;
            end
            `IDX_HALF_CYCLES: regWord = {16'h0000, st_r.halfCycles};
            `IDX_STATUS:      regWord[`DONE_BIT] = st_r.statusDone;
            `IDX_MASK:        regWord[`DONE_BIT] = st_r.maskDone;
            `IDX_THR_LOW:     regWord = st_r.threshold[31:0];
            `IDX_THR_HIGH:    regWord = {16'h0000, st_r.threshold[47:32]};
            default:
            begin
                if (regIdx >= `IDX_TOTAL_A && regIdx <= `IDX_FUND_C)
                begin
                    regWord = st_r.lineEnable
                            ? st_r.energyReg[regIdx - `IDX_TOTAL_A]   // see RQ2
                            : st_r.energyAcc[regIdx - `IDX_TOTAL_A];
                end
                else if (regIdx >= `IDX_REACT_A && regIdx <= `IDX_REACT_C)
                begin
                    regWord = st_r.reactWave[regIdx - `IDX_REACT_A];  // see RQ13
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        st_nxt    = st_r;
        firstSum  = '0;
        thrExt    = 52'(st_r.threshold);
        delta     = '0;
        netTotal  = '0;
        anyTotal  = 1'b0;
        merged    = beMerge(regWord, avsReq.writedata, avsReq.byteenable);
        clearBits = beMerge(32'h0000_0000, avsReq.writedata, avsReq.byteenable);
        reactShift = '0;
        readClear = 1'b0;

        // Sample tick divider
        st_nxt.tick    = (st_r.tickCnt == TICK_LAST);                  // see RQ16
        st_nxt.tickCnt = st_nxt.tick ? '0 : st_r.tickCnt + 16'h0001;

        // Bus answer: one wait cycle, then the access completes
        case (st_r.busState)
            BUS_IDLE:
            begin
                if (avsReq.read || avsReq.write)
                begin
                    st_nxt.busState = BUS_ACK;
                    st_nxt.waitreq  = 1'b0;
                    st_nxt.readData = regWord;
                end
            end
            BUS_ACK:
            begin
                st_nxt.busState = BUS_IDLE;
                st_nxt.waitreq  = 1'b1;
                // Ignored in line mode, where it is unavailable
                readClear = avsReq.read && st_r.clearOnRead && !st_r.lineEnable
                          && regIdx >= `IDX_TOTAL_A && regIdx <= `IDX_FUND_C;
                if (avsReq.write)
                begin
                    case (regIdx)
                        `IDX_ACC_MODE:
                        begin
                            st_nxt.pulseMode  = merged[`PULSE_MODE_MSB:`PULSE_MODE_LSB];
                            st_nxt.phaseBForm = merged[`PHASE_B_MSB:`PHASE_B_LSB];
                        end
                        `IDX_LINE_MODE:
                        begin
                            st_nxt.lineEnable  = merged[`LINE_EN_BIT];        // see RQ3
                            st_nxt.clearOnRead = merged[`CLEAR_READ_BIT];
                            st_nxt.zxSelect    = merged[`ZX_SEL_MSB:`ZX_SEL_LSB];
                        end
                        `IDX_HALF_CYCLES: st_nxt.halfCycles = merged[15:0];   // see RQ7
                        `IDX_MASK:        st_nxt.maskDone   = merged[`DONE_BIT];
                        `IDX_THR_LOW:     st_nxt.threshold[31:0] = merged;
                        `IDX_THR_HIGH:
                            st_nxt.threshold[47:32] = merged[`THR_HIGH_MSB:0];
                        default:
                        begin
                            // Read-only and unmapped words ignore writes
                        end
                    endcase
                end
            end
            default:
            begin
                st_nxt.busState = BUS_IDLE;
                st_nxt.waitreq  = 1'b1;
            end
        endcase

        // Energy channels: first stage then pulse accumulation
        for (int ch = 0; ch < 6; ch++)
        begin
            delta    = '0;
            firstSum = 52'(signed'(st_r.firstAcc[ch])) + 52'(chanPow[ch]);
            if (st_r.tick)
            begin
                if (firstSum > 0 && firstSum >= thrExt)
                begin
                    delta    = 32'sh0000_0001;                          // see RQ16
                    firstSum = firstSum - thrExt;
                end
                else if (firstSum < 0 && firstSum <= -thrExt)
                begin
                    delta    = -32'sh0000_0001;                         // see RQ16
                    firstSum = firstSum + thrExt;
                end
                st_nxt.firstAcc[ch] = firstSum[47:0];
            end
            if (ch < 3)
            begin
                netTotal = netTotal + 3'(delta);
                anyTotal = anyTotal | (delta != 0);
            end
            // Line mode reuses the same accumulators, same weight per bit
            if (lineDone)
            begin
                st_nxt.energyReg[ch] = st_r.energyAcc[ch] + delta;      // see RQ2, RQ11
                st_nxt.energyAcc[ch] = '0;
            end
            else if (readClear && regIdx == 6'(ch) + `IDX_TOTAL_A)
            begin
                st_nxt.energyAcc[ch] = delta;       // Pulse in this cycle survives
            end
            else
            begin
                st_nxt.energyAcc[ch] = st_r.energyAcc[ch] + delta;      // see RQ11
            end
        end

        // Pulse output; watt-hour words stay signed regardless
        st_nxt.cfPulse = (st_r.pulseMode == `PULSE_ABSOLUTE)
                       ? anyTotal : (netTotal > 0);                     // see RQ1

        // Reactive waveform words, one sixteenth of the product
        for (int p = 0; p < 3; p++)
        begin
            reactShift = reactProd[p] >>> `REACT_SHIFT;
            if (st_r.tick)
            begin
                st_nxt.reactWave[p] = reactShift[31:0];                 // see RQ13
            end
        end

        // Done flag: a new period end wins over a clear
        if (st_r.busState == BUS_ACK && avsReq.write && regIdx == `IDX_STATUS)
        begin
            st_nxt.statusDone = st_r.statusDone & ~clearBits[`DONE_BIT]; // see RQ10
        end
        if (lineDone)
        begin
            st_nxt.statusDone = 1'b1;                                   // see RQ9
        end
        st_nxt.irqN = !(st_nxt.statusDone && st_nxt.maskDone);          // see RQ9, RQ10
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= ST_RESET;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign avs_readdata           = st_r.readData;
    assign avs_waitrequest        = st_r.waitreq;
    assign pulse_frequency_output = st_r.cfPulse;
    assign interrupt_out_n        = st_r.irqN;

endmodule
`default_nettype wire

// >>> design/energy_acc_defs.svh
`ifndef ENERGY_ACC_DEFS_SVH
`define ENERGY_ACC_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLOCK_PERIOD_PS     5000
`define SAMPLE_PERIOD_US    125
`define PS_PER_US           1000000

// ----------------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_ACC_MODE        6'h00
`define IDX_LINE_MODE       6'h01
`define IDX_HALF_CYCLES     6'h02
`define IDX_STATUS          6'h03
`define IDX_MASK            6'h04
`define IDX_THR_LOW         6'h05
`define IDX_THR_HIGH        6'h06
`define IDX_TOTAL_A         6'h07
`define IDX_FUND_C          6'h0c
`define IDX_REACT_A         6'h0d
`define IDX_REACT_C         6'h0f

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PULSE_MODE_LSB      0
`define PULSE_MODE_MSB      1
`define PHASE_B_LSB         4
`define PHASE_B_MSB         5
`define LINE_EN_BIT         0
`define CLEAR_READ_BIT      6
`define ZX_SEL_LSB          3
`define ZX_SEL_MSB          5
`define DONE_BIT            5
`define THR_HIGH_MSB        15
`define REACT_SHIFT         4

// ----------------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------------
`define PULSE_ABSOLUTE      2'h1
`define PHB_NORMAL          2'h0
`define PHB_ZERO            2'h1
`define PHB_NEG_A_C         2'h2
`define PHB_NEG_A           2'h3
`define FULL_SCALE_POWER    48'h0000_01ff_6a6b
`define HALF_CYCLES_RESET   16'h0064

`endif

// >>> design/energy_acc_pkg.sv
package energy_acc_pkg;

    // One phase worth of DSP samples
    typedef struct packed {
        logic signed [23:0] volt;      // Voltage sample
        logic signed [23:0] curr;      // Current sample
        logic signed [23:0] currQuad;  // Current shifted by a quarter period
    } phaseSample_s;

    // Avalon-MM request group
    typedef struct packed {
        logic [7:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avalonReq_s;

    // Bus answer state, Gray along idle -> ack
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } busState_e;

    // Zero-crossing counter state
    typedef struct packed {
        logic [16:0] count;
        logic        done;
    } zxState_s;

    // Whole state of the accumulator top
    typedef struct packed {
        busState_e          busState;
        logic               waitreq;
        logic [31:0]        readData;
        logic [1:0]         pulseMode;
        logic [1:0]         phaseBForm;
        logic               lineEnable;
        logic               clearOnRead;
        logic [2:0]         zxSelect;
        logic [15:0]        halfCycles;
        logic [47:0]        threshold;
        logic               statusDone;
        logic               maskDone;
        logic               irqN;
        logic               cfPulse;
        logic [15:0]        tickCnt;
        logic               tick;
        logic [5:0][47:0]   firstAcc;
        logic [5:0][31:0]   energyAcc;
        logic [5:0][31:0]   energyReg;
        logic [2:0][31:0]   reactWave;
    } accState_s;

endpackage

// >>> design/zero_cross_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "energy_acc_defs.svh"

module zero_cross_counter
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [2:0]  zeroCross,     // Per-phase crossing pulses
    input  wire logic [2:0]  phaseSelect,   // Phases that count
    input  wire logic [15:0] target,        // Half cycles per period
    input  wire logic        restart,       // Clear the count
    output logic             done           // One-cycle period end
);
    import energy_acc_pkg::*;

    zxState_s    st_r;     // Registered state
    zxState_s    st_nxt;   // Next state
    logic [1:0]  inc;      // Crossings counted this cycle
    logic [16:0] sum;      // Count after this cycle

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Counts whatever the mode, so the first period after enabling
    // line mode may be short unless software restarts it.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        inc = 2'(zeroCross[0] & phaseSelect[0])    // see RQ5
            + 2'(zeroCross[1] & phaseSelect[1])
            + 2'(zeroCross[2] & phaseSelect[2]);
        sum = st_r.count + 17'(inc);
        if (restart)
        begin
            st_nxt.count = '0;                     // see RQ8
        end
        else if (inc != 2'h0 && sum >= {1'b0, target})
        begin
            // Extra crossings in the same cycle are dropped
            st_nxt.count = '0;                     // see RQ18
            st_nxt.done  = 1'b1;                   // see RQ7
        end
        else
        begin
            st_nxt.count = sum;                    // see RQ8
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign done = st_r.done;

endmodule
`default_nettype wire

// >>> test/energy_acc_sva.sv
`timescale 1ns/1ps
`default_nettype none
module energy_acc_sva
    import energy_acc_pkg::*;
#(parameter int unsigned SAMPLE_CYCLES = 8)
(
    input wire logic                      clock,
    input wire logic                      rst_n,
    input wire energy_acc_pkg::avalonReq_s avsReq,
    input wire logic [31:0]               avs_readdata,
    input wire logic                      avs_waitrequest,
    input wire energy_acc_pkg::phaseSample_s [2:0] samples,
    input wire logic [2:0][47:0]          fundPower,
    input wire logic [2:0]                zeroCross,
    input wire logic                      pulse_frequency_output,
    input wire logic                      interrupt_out_n
);
    // Completed accesses; status or mask writes may move the interrupt
    wire logic [5:0] idx    = avsReq.address[7:2];
    wire logic       wrDone = avsReq.write && !avs_waitrequest;
    wire logic       rdDone = avsReq.read && !avs_waitrequest;
    wire logic       stWr   = wrDone && (idx == 6'h03 || idx == 6'h04);
    wire logic       anyZx  = |zeroCross;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
    wait_answer_a: assert property ((avsReq.read || avsReq.write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no bus answer");
    irq_fall_a: assert property ($fell(interrupt_out_n) |->
        $past(anyZx, 2) || $past(stWr)) else $error("irq fell without cause");
    irq_rise_a: assert property ($rose(interrupt_out_n) |-> $past(stWr))
        else $error("irq rose without write");
    irq_hold_a: assert property (!interrupt_out_n && !stWr |=> !interrupt_out_n)
        else $error("irq not sticky");
    pulse_one_a: assert property ($rose(pulse_frequency_output) |=>
        !pulse_frequency_output) else $error("pulse too long");
    count_width_a: assert property (rdDone && idx == 6'h02 |->
        avs_readdata[31:16] == 16'h0) else $error("count wider than 16");
    status_bits_a: assert property (rdDone && idx == 6'h03 |->
        (avs_readdata & ~32'h20) == 0) else $error("status spare bits");
    cover property ($fell(interrupt_out_n));
    cover property (pulse_frequency_output);
    cover property (stWr);
endmodule
`default_nettype wire

// >>> test/host_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_master
(
    input wire logic                   clock,
    output var energy_acc_pkg::avalonReq_s req,
    input wire logic                   waitReq,
    input wire logic [31:0]            rdata
);
    import energy_acc_pkg::*;
    initial req = '0;
    // One access; held until waitrequest is seen low at a rising edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] rd);
        @(posedge clock);
        req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
        do @(posedge clock); while (waitReq !== 1'b0);
        rd = rdata;
        req <= '0;
    endtask
endmodule
`default_nettype wire

// >>> test/tb_line_cycle_energy_accumulator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_line_cycle_energy_accumulator;
    import energy_acc_pkg::*;
    localparam int unsigned SC = 8; // Short sample period
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    avalonReq_s avsReq;
    logic [31:0] rdata, rd, e1, v;
    logic waitReq, pfo, irqN;
    phaseSample_s [2:0] samples = '0;
    logic [2:0][47:0] fundPower = '0;
    logic [2:0] zeroCross = '0;
    int err_count = 0;
    int checked = 0;
    int i;
    always #2.5 clock = ~clock;
    line_cycle_energy_accumulator #(.SAMPLE_CYCLES(SC)) dut (.clock(clock), .rst_n(rst_n),
        .avsReq(avsReq), .avs_readdata(rdata), .avs_waitrequest(waitReq), .samples(samples),
        .fundPower(fundPower), .zeroCross(zeroCross), .pulse_frequency_output(pfo),
        .interrupt_out_n(irqN));
    host_master host (.clock(clock), .req(avsReq), .waitReq(waitReq), .rdata(rdata));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s exp %h got %h", nm, exp, got);
            err_count++;
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        host.access(1'b0, a, '0, rd);
        chk(nm, exp, rd);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.access(1'b1, a, d, rd);
        // Let the completion edge land before anything is looked at
        @(posedge clock);
    endtask
    // One crossing pulse on a phase, then time for the period end to land
    task automatic zc(input int ph);
        @(posedge clock);
        zeroCross <= 3'(1 << ph);
        @(posedge clock);
        zeroCross <= '0;
        repeat (3) @(posedge clock);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        results();
    end
    initial
    begin
        i = $urandom(32'h0a1afadf);
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rdchk(8'h00, 0, "acc mode");
        rdchk(8'h04, 0, "line mode");
        rdchk(8'h08, 32'h64, "half cycles");
        rdchk(8'h14, 32'h01ff6a6b, "thr low");
        rdchk(8'h0c, 0, "status");
        $display("test reset done");
        for (i = 0; i < 4; i++)
        begin
            v = $urandom;
            v[1:0] = 2'(i);
            v[5:4] = 2'(3 - i);
            wr(8'h00, v);
            rdchk(8'h00, v & 32'h33, "acc mode");
        end
        wr(8'h1c, $urandom);
        rdchk(8'h1c, 0, "energy write");
        rdchk(8'h80, 0, "unmapped");
        $display("test fields done");
        samples <= 216'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
        fundPower[0] <= 48'h1;
        wr(8'h14, 1);
        wr(8'h10, 32'h20);
        wr(8'h04, 32'h09);
        wr(8'h08, 3);
        zc(0);
        zc(1);
        zc(0);
        chk("irq", 1, irqN);
        zc(0);
        chk("irq", 0, irqN);
        rdchk(8'h0c, 32'h20, "status");
        host.access(1'b0, 8'h28, '0, e1);
        chk("fund nonzero", 1, e1 != 0);
        repeat (3 * SC) @(posedge clock);
        rdchk(8'h28, e1, "fund held");
        wr(8'h0c, 32'h20);
        chk("irq", 1, irqN);
        rdchk(8'h0c, 0, "status");
        for (i = 0; i < 3; i++) zc(0);
        chk("irq", 0, irqN);
        wr(8'h10, 0);
        chk("irq", 1, irqN);
        wr(8'h00, 1);
        // Threshold 1: every tick pulses, so absolute mode gives one per tick
        i = 0;
        repeat (4 * SC)
        begin
            @(posedge clock);
            i += pfo;
        end
        chk("pulse count", 4, i);
        rdchk(8'h34, 32'((longint'(samples[0].volt) * samples[0].currQuad) >>> 4),
              "react a");
        $display("test line cycle done");
        results();
    end
endmodule
bind line_cycle_energy_accumulator energy_acc_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) sva (
    .clock(clock), .rst_n(rst_n), .avsReq(avsReq), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .samples(samples), .fundPower(fundPower),
    .zeroCross(zeroCross), .pulse_frequency_output(pulse_frequency_output),
    .interrupt_out_n(interrupt_out_n));
`default_nettype wire
